// ---- hw/pic_consts.vh ----
// constants for the host-side controller of the prioritized interrupt controller
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH
// apb register byte offsets
`define PIC_OFS_CMD 8'h00
`define PIC_OFS_STATUS 8'h04
`define PIC_OFS_RDATA 8'h08
`define PIC_OFS_ACKDATA 8'h0c
`define PIC_OFS_CFG 8'h10
`define PIC_OFS_INIT1 8'h14
`define PIC_OFS_INIT2 8'h18
`define PIC_OFS_INIT3 8'h1c
`define PIC_OFS_INIT4 8'h20
// command register fields
`define PIC_CMD_OP_LSB 0
`define PIC_CMD_A0_BIT 8
`define PIC_CMD_DATA_LSB 16
// command opcodes
`define PIC_OP_NOP 3'h0
`define PIC_OP_WRITE 3'h1
`define PIC_OP_READ 3'h2
`define PIC_OP_ACK 3'h3
`define PIC_OP_INIT 3'h4
// config register bits
`define PIC_CFG_VECTOR 0
`define PIC_CFG_AUTO_ACK 1
`define PIC_CFG_AUTO_END 2
// device word fields
`define PIC_W1_START_BIT 4
`define PIC_W1_SINGLE_BIT 1
`define PIC_W1_W4_BIT 0
`define PIC_END_CMD 8'h20
`define PIC_ACK_CALL_PULSES 3'h3
`define PIC_ACK_VEC_PULSES 3'h2
// reset values
`define PIC_CFG_RESET 3'h0
`define PIC_INIT1_RESET 8'h13
// timing in ns and in 20 ns clock cycles, least times rounded up
`define PIC_CLK_NS 20
`define PIC_RD_LOW_NS 160
`define PIC_WR_LOW_NS 120
`define PIC_ACK_LOW_NS 160
`define PIC_RECOV_NS 250
`define PIC_SYNC_CYC 2
`define PIC_RD_LOW_CYC ((`PIC_RD_LOW_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS + `PIC_SYNC_CYC)
`define PIC_WR_LOW_CYC ((`PIC_WR_LOW_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS)
`define PIC_ACK_LOW_CYC ((`PIC_ACK_LOW_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS + `PIC_SYNC_CYC)
`define PIC_RECOV_CYC ((`PIC_RECOV_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS)
`endif

// ---- hw/pic_host_ctrl.v ----
// host-side controller that drives the interrupt controller's bus and acknowledge pins
// What this block does
// - host acknowledges with low pulses; device returns one byte per pulse
// - host sends end-of-service after the acknowledge pulses only when the auto-end config bit is set
// - host writes init words consecutively in order; third gives slave map
// - host writes mask, priority and mode commands freely after initialization
// - host sends three pulses in call mode, two in vector mode
`timescale 1ns/100ps
`include "pic_consts.vh"

module pic_host_ctrl #(
  parameter DW = 8
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [DW-1:0] dev_data_i,
  output reg [DW-1:0] dev_data_o,
  output reg dev_data_oe_o,
  output reg dev_cs_n_o,
  output reg dev_rd_n_o,
  output reg dev_wr_n_o,
  output reg dev_a0_o,
  output reg acknowledge_strobe_n_o,
  input wire dev_int_i
);

  localparam ST_IDLE = 5'b00001;
  localparam ST_ISSUE = 5'b00010;
  localparam ST_SET = 5'b00100;
  localparam ST_LOW = 5'b01000;
  localparam ST_GAP = 5'b10000;
  localparam K_WR = 2'd0;
  localparam K_RD = 2'd1;
  localparam K_ACK = 2'd2;
  // strobe and gap counts less one, cut to the counter width where loaded
  localparam [31:0] WR_LOW_M1 = `PIC_WR_LOW_CYC - 1;
  localparam [31:0] RD_LOW_M1 = `PIC_RD_LOW_CYC - 1;
  localparam [31:0] ACK_LOW_M1 = `PIC_ACK_LOW_CYC - 1;
  localparam [31:0] RECOV_M1 = `PIC_RECOV_CYC - 1;

  reg [4:0] st_q;
  reg [2:0] op_q;
  reg [2:0] step_q;
  reg [4:0] cnt_q;
  reg [1:0] kind_q;
  reg [2:0] cfg_q;
  reg [7:0] w1_q;
  reg [7:0] w2_q;
  reg [7:0] w3_q;
  reg [7:0] w4_q;
  reg [7:0] cmd_data_q;
  reg cmd_a0_q;
  reg [7:0] rdata_q;
  reg [23:0] ack_data_q;
  reg init_done_q;
  reg [DW-1:0] din_s1_q;
  reg [DW-1:0] din_s2_q;
  reg int_s1_q;
  reg int_s2_q;

  reg nx_valid;
  reg [1:0] nx_kind;
  reg nx_a0;
  reg [7:0] nx_data;
  reg [31:0] rd_mux;
  reg addr_ok;

  wire busy = (st_q != ST_IDLE);
  wire [2:0] ack_pulses = cfg_q[`PIC_CFG_VECTOR] ? `PIC_ACK_VEC_PULSES : `PIC_ACK_CALL_PULSES;
  wire need_w3 = ~w1_q[`PIC_W1_SINGLE_BIT];
  wire need_w4 = w1_q[`PIC_W1_W4_BIT];
  wire apb_wr = psel_i & penable_i & pready_o & pwrite_i;
  wire cmd_wr = apb_wr & (paddr_i == `PIC_OFS_CMD);
  wire [2:0] cmd_op = pwdata_i[`PIC_CMD_OP_LSB +: 3];
  wire auto_ack = cfg_q[`PIC_CFG_AUTO_ACK] & init_done_q & int_s2_q;

  // asynchronous pins pass two flip-flops first
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      din_s1_q <= {DW{1'b0}};
      din_s2_q <= {DW{1'b0}};
      int_s1_q <= 1'b0;
      int_s2_q <= 1'b0;
    end else begin
      din_s1_q <= dev_data_i;
      din_s2_q <= din_s1_q;
      int_s1_q <= dev_int_i;
      int_s2_q <= int_s1_q;
    end
  end

  // next device access of the running operation
  always @* begin
    nx_valid = 1'b0;
    nx_kind = K_WR;
    nx_a0 = 1'b0;
    nx_data = 8'h00;
    case (op_q)
      `PIC_OP_INIT: begin
        nx_valid = 1'b1;
        if (step_q == 3'd0) begin
          nx_data = w1_q | (8'h01 << `PIC_W1_START_BIT);
        end else if (step_q == 3'd1) begin
          nx_a0 = 1'b1;
          nx_data = w2_q;
        end else if (step_q == 3'd2 && need_w3) begin
          nx_a0 = 1'b1;
          nx_data = w3_q;
        end else if (need_w4 && (step_q == (need_w3 ? 3'd3 : 3'd2))) begin
          nx_a0 = 1'b1;
          nx_data = w4_q;
        end else begin
          nx_valid = 1'b0;
        end
      end
      `PIC_OP_ACK: begin
        if (step_q < ack_pulses) begin
          nx_valid = 1'b1;
          nx_kind = K_ACK;
        end else if (step_q == ack_pulses && cfg_q[`PIC_CFG_AUTO_END]) begin
          nx_valid = 1'b1;
          nx_data = `PIC_END_CMD;
        end
      end
      `PIC_OP_WRITE: begin
        nx_valid = (step_q == 3'd0);
        nx_a0 = cmd_a0_q;
        nx_data = cmd_data_q;
      end
      `PIC_OP_READ: begin
        nx_valid = (step_q == 3'd0);
        nx_kind = K_RD;
        nx_a0 = cmd_a0_q;
      end
      default: begin
        nx_valid = 1'b0;
      end
    endcase
  end

  // device pin sequencer
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      op_q <= `PIC_OP_NOP;
      step_q <= 3'd0;
      cnt_q <= 5'd0;
      kind_q <= K_WR;
      cmd_data_q <= 8'h00;
      cmd_a0_q <= 1'b0;
      rdata_q <= 8'h00;
      ack_data_q <= 24'h000000;
      init_done_q <= 1'b0;
      dev_data_o <= {DW{1'b0}};
      dev_data_oe_o <= 1'b0;
      dev_cs_n_o <= 1'b1;
      dev_rd_n_o <= 1'b1;
      dev_wr_n_o <= 1'b1;
      dev_a0_o <= 1'b0;
      acknowledge_strobe_n_o <= 1'b1;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (cmd_wr && cmd_op != `PIC_OP_NOP) begin
            op_q <= cmd_op;
            step_q <= 3'd0;
            cmd_a0_q <= pwdata_i[`PIC_CMD_A0_BIT];
            cmd_data_q <= pwdata_i[`PIC_CMD_DATA_LSB +: 8];
            if (cmd_op == `PIC_OP_INIT) begin
              init_done_q <= 1'b0;
            end
            st_q <= ST_ISSUE;
          end else if (auto_ack) begin
            op_q <= `PIC_OP_ACK;
            step_q <= 3'd0;
            st_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (nx_valid) begin
            kind_q <= nx_kind;
            dev_a0_o <= nx_a0;
            dev_cs_n_o <= (nx_kind == K_ACK); // acknowledge runs without select
            dev_data_o <= nx_data[DW-1:0];
            dev_data_oe_o <= (nx_kind == K_WR);
            st_q <= ST_SET;
          end else begin
            if (op_q == `PIC_OP_INIT) begin
              init_done_q <= 1'b1;
            end
            op_q <= `PIC_OP_NOP;
            st_q <= ST_IDLE;
          end
        end
        ST_SET: begin
          dev_rd_n_o <= (kind_q != K_RD);
          dev_wr_n_o <= (kind_q != K_WR);
          acknowledge_strobe_n_o <= (kind_q != K_ACK);
          cnt_q <= (kind_q == K_WR) ? WR_LOW_M1[4:0] :
                   (kind_q == K_RD) ? RD_LOW_M1[4:0] : ACK_LOW_M1[4:0];
          st_q <= ST_LOW;
        end
        ST_LOW: begin
          if (cnt_q != 5'd0) begin
            cnt_q <= cnt_q - 5'd1;
          end else begin
            if (kind_q == K_RD) begin
              rdata_q <= din_s2_q[7:0];
            end
            if (kind_q == K_ACK) begin
              ack_data_q[step_q[1:0]*8 +: 8] <= din_s2_q[7:0];
            end
            dev_rd_n_o <= 1'b1;
            dev_wr_n_o <= 1'b1;
            acknowledge_strobe_n_o <= 1'b1;
            cnt_q <= RECOV_M1[4:0];
            st_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          dev_cs_n_o <= 1'b1;
          dev_data_oe_o <= 1'b0;
          if (cnt_q != 5'd0) begin
            cnt_q <= cnt_q - 5'd1;
          end else begin
            step_q <= step_q + 3'd1;
            st_q <= ST_ISSUE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // apb register decode
  always @* begin
    addr_ok = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr_i)
      `PIC_OFS_CMD: rd_mux = {8'h00, cmd_data_q, 7'h00, cmd_a0_q, 5'h00, op_q};
      `PIC_OFS_STATUS: rd_mux = {29'h0, init_done_q, int_s2_q, busy};
      `PIC_OFS_RDATA: rd_mux = {24'h0, rdata_q};
      `PIC_OFS_ACKDATA: rd_mux = {8'h00, ack_data_q};
      `PIC_OFS_CFG: rd_mux = {29'h0, cfg_q};
      `PIC_OFS_INIT1: rd_mux = {24'h0, w1_q};
      `PIC_OFS_INIT2: rd_mux = {24'h0, w2_q};
      `PIC_OFS_INIT3: rd_mux = {24'h0, w3_q};
      `PIC_OFS_INIT4: rd_mux = {24'h0, w4_q};
      default: addr_ok = 1'b0;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      cfg_q <= `PIC_CFG_RESET;
      w1_q <= `PIC_INIT1_RESET;
      w2_q <= 8'h00;
      w3_q <= 8'h00;
      w4_q <= 8'h00;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~addr_ok;
      prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? rd_mux : 32'h00000000;
      if (apb_wr) begin
        case (paddr_i)
          `PIC_OFS_CFG: cfg_q <= pwdata_i[2:0];
          `PIC_OFS_INIT1: w1_q <= pwdata_i[7:0];
          `PIC_OFS_INIT2: w2_q <= pwdata_i[7:0];
          `PIC_OFS_INIT3: w3_q <= pwdata_i[7:0];
          `PIC_OFS_INIT4: w4_q <= pwdata_i[7:0];
          default: cfg_q <= cfg_q;
        endcase
      end
    end
  end

endmodule

// ---- tb/pic_dev_model.sv ----
// behavioural model of the interrupt controller device, call and vector modes, fixed priority
`timescale 1ns/100ps
module pic_dev_model #(
  // position of the vector-mode bit in the fourth word
  parameter VEC_BIT = 0
) (
  input wire cs_n_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire a0_i,
  input wire ack_n_i,
  input wire [7:0] data_i,
  input wire [7:0] req_i,
  output wire [7:0] data_o,
  output wire int_o
);
  reg [7:0] request_pending_reg = 8'h00;
  reg [7:0] in_service_reg = 8'h00;
  reg [7:0] level_mask_reg = 8'h00;
  reg [7:0] iw1 = 8'h00, iw2 = 8'h00, iw4 = 8'h00, prev = 8'h00, drv = 8'h00;
  integer step = 0, pulse = 0, sel = 0, lev = 0;
  function integer first(input [7:0] v);
    integer k;
    begin
      first = 8;
      for (k = 7; k >= 0; k = k - 1)
        if (v[k]) first = k;
    end
  endfunction
  assign int_o = first(request_pending_reg & ~level_mask_reg) < first(in_service_reg);
  // a released bus shows the inverse of the last driven byte
  assign data_o = (!ack_n_i || (!cs_n_i && !rd_n_i)) ? drv : ~drv;
  always @(req_i) begin
    request_pending_reg = request_pending_reg | (req_i & ~prev);
    prev = req_i;
  end
  always @(posedge wr_n_i) if (!cs_n_i) begin
    if (!a0_i && data_i[4]) begin
      {request_pending_reg, in_service_reg, level_mask_reg} = 24'h0;
      iw1 = data_i;
      iw4 = 8'h00;
      step = 2;
      sel = 0;
      pulse = 0;
    end else if (!a0_i && !data_i[3]) begin
      lev = data_i[6] ? data_i[2:0] : first(in_service_reg);
      if (data_i[5] && lev < 8) in_service_reg[lev] = 1'b0;
    end else if (!a0_i) begin
      if (data_i[1]) sel = data_i[0];
    end else if (step == 2) begin
      iw2 = data_i;
      step = !iw1[1] ? 3 : iw1[0] ? 4 : 0;
    end else if (step == 3) step = iw1[0] ? 4 : 0;
    else if (step == 4) begin
      iw4 = data_i;
      step = 0;
    end else level_mask_reg = data_i;
  end
  always @(negedge rd_n_i or negedge ack_n_i) begin
    if (!ack_n_i && iw4[VEC_BIT]) begin
      pulse = pulse + 1;
      if (pulse == 1) lev = first(request_pending_reg & ~level_mask_reg);
      if (pulse == 2) begin
        drv = {iw2[7:3], lev[2:0]};
        in_service_reg[lev] = 1'b1;
        request_pending_reg[lev] = 1'b0;
        pulse = 0;
      end
    end else if (!ack_n_i) begin
      pulse = pulse + 1;
      if (pulse == 1) lev = first(request_pending_reg & ~level_mask_reg);
      drv = pulse == 1 ? 8'hcd : pulse == 3 ? iw2 : iw1[2] ?
        {iw1[7:5], lev[2:0], 2'b00} : {iw1[7:6], lev[2:0], 3'b000};
      if (pulse == 3) begin
        in_service_reg[lev] = 1'b1;
        request_pending_reg[lev] = 1'b0;
        pulse = 0;
      end
    end else if (!cs_n_i)
      drv = a0_i ? level_mask_reg : sel ? in_service_reg : request_pending_reg;
  end
endmodule

// ---- tb/pic_host_asserts.sv ----
// port checker for the host-side interrupt controller driver
`timescale 1ns/100ps
module pic_host_asserts #(
  parameter DW = 8
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire [DW-1:0] dev_data_o,
  input wire dev_data_oe_o,
  input wire dev_cs_n_o,
  input wire dev_rd_n_o,
  input wire dev_wr_n_o,
  input wire acknowledge_strobe_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  apb_answer_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  ready_access_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  error_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  write_width_a: assert property ($fell(dev_wr_n_o) |->
    !dev_wr_n_o[*6] ##1 dev_wr_n_o)
    else $error("write strobe width");
  ack_width_a: assert property ($fell(acknowledge_strobe_n_o) |->
    !acknowledge_strobe_n_o[*8] ##1 !acknowledge_strobe_n_o[*2] ##1 acknowledge_strobe_n_o)
    else $error("ack strobe width");
  read_width_a: assert property ($fell(dev_rd_n_o) |->
    !dev_rd_n_o[*8] ##1 !dev_rd_n_o[*2] ##1 dev_rd_n_o)
    else $error("read strobe width");
  ack_unselected_a: assert property (!acknowledge_strobe_n_o |->
    dev_cs_n_o && !dev_data_oe_o)
    else $error("select or drive during ack");
  write_held_a: assert property (!dev_wr_n_o |->
    !dev_cs_n_o && dev_data_oe_o && dev_rd_n_o && $stable(dev_data_o))
    else $error("write data not held");
  cover property ($fell(acknowledge_strobe_n_o));
  cover property ($fell(dev_rd_n_o));
  cover property (pslverr_o);
endmodule

// ---- tb/pic_host_ctrl_test.sv ----
// self-checking bench for the host-side interrupt controller driver
`timescale 1ns/100ps
module pic_host_ctrl_test;
  reg core_clk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  reg [7:0] paddr = 8'h00, req = 8'h00, mask, v2;
  reg [31:0] pwdata = 32'h0, rd, lfsr = 32'h48602ed1;
  wire [31:0] prdata;
  wire pready, pslverr, oe, cs_n, rd_n, wr_n, a0, ack_n, dev_int;
  wire [7:0] dout, mdata;
  wire [7:0] bus = oe ? dout : mdata;
  integer errors = 0, n_checks = 0, m_irr = 0, lev, i;
  pic_host_ctrl u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .dev_data_i(bus),
    .dev_data_o(dout), .dev_data_oe_o(oe), .dev_cs_n_o(cs_n), .dev_rd_n_o(rd_n),
    .dev_wr_n_o(wr_n), .dev_a0_o(a0), .acknowledge_strobe_n_o(ack_n), .dev_int_i(dev_int));
  pic_dev_model u_dev (.cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .a0_i(a0),
    .ack_n_i(ack_n), .data_i(bus), .req_i(req), .data_o(mdata), .int_o(dev_int));
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task stop_test;
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge core_clk_i);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk_i);
    penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // device command through the command register, then wait until not busy
  task dev(input [2:0] op, input a, input [7:0] d);
    apb(1, 8'h00, {8'h00, d, 7'h0, a, 5'h0, op});
    rd = 1;
    while (rd[0] === 1'b1) apb(0, 8'h04, 0);
  endtask
  bind pic_host_ctrl pic_host_asserts #(.DW(DW)) u_chk (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .dev_data_o(dev_data_o), .dev_data_oe_o(dev_data_oe_o),
    .dev_cs_n_o(dev_cs_n_o), .dev_rd_n_o(dev_rd_n_o), .dev_wr_n_o(dev_wr_n_o),
    .acknowledge_strobe_n_o(acknowledge_strobe_n_o));
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial begin
    #400000;
    errors = errors + 1;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    apb(0, 8'h40, 0);
    chk({rd[30:0], err}, 32'h1);
    lfsr = nxt(lfsr);
    v2 = lfsr[7:0];
    // single controller, fourth word present, 8-byte address gap
    apb(1, 8'h14, 32'h93);
    apb(1, 8'h18, {24'h0, v2});
    apb(1, 8'h20, 32'h0);
    apb(1, 8'h10, 32'h4);
    dev(3'h4, 0, 0);
    req <= 8'hff;
    m_irr = 8'hff;
    for (i = 0; i < 10; i = i + 1) begin
      lfsr = nxt(lfsr);
      mask = lfsr[7:0] & lfsr[15:8];
      dev(3'h1, 1, mask);
      dev(3'h2, 1, 0);
      apb(0, 8'h08, 0);
      chk(rd, mask);
      dev(3'h2, 0, 0);
      apb(0, 8'h08, 0);
      chk(rd, m_irr);
      apb(0, 8'h04, 0);
      chk(rd & 2, (m_irr & ~mask) ? 2 : 0);
      if ((m_irr & ~mask) != 0) begin
        lev = 0;
        while (((m_irr & ~mask) >> lev) % 2 == 0) lev = lev + 1;
        dev(3'h3, 0, 0);
        apb(0, 8'h0c, 0);
        chk(rd, {8'h00, v2, 2'b10, lev[2:0], 3'h0, 8'hcd});
        m_irr = m_irr & ~(1 << lev);
      end
    end
    // vector mode; auto acknowledge is enabled only once the new setup is done
    apb(1, 8'h20, 32'h1);
    apb(1, 8'h10, 32'h5);
    dev(3'h4, 0, 0);
    apb(1, 8'h10, 32'h7);
    lfsr = nxt(lfsr);
    lev = lfsr[2:0];
    req <= 8'h00;
    @(posedge core_clk_i);
    req <= 8'h01 << lev;
    // let the request pass the synchroniser before polling for quiet
    repeat (4) @(posedge core_clk_i);
    rd = 3;
    while (rd[1:0] !== 2'b00) apb(0, 8'h04, 0);
    apb(0, 8'h0c, 0);
    chk(rd[15:8], {v2[7:3], lev[2:0]});
    dev(3'h1, 1, 8'hff);
    req <= 8'hff;
    dev(3'h2, 0, 0);
    apb(0, 8'h08, 0);
    chk(rd, 8'hff & ~(8'h01 << lev));
    // in-service selected once, then read twice: auto finish left it empty
    for (i = 0; i < 2; i = i + 1) begin
      if (i == 0) dev(3'h1, 0, 8'h0b);
      dev(3'h2, 0, 0);
      apb(0, 8'h08, 0);
      chk(rd, 0);
    end
    stop_test;
  end
endmodule
